// ### hw/alarm_period_control.sv
// Alarm control registers, alarm pin routing and update-period timing.
`timescale 1ns/1ps
module alarm_period_control #(
	parameter int TB_SHORT_CYCLES = alarm_period_pkg::TB_SHORT_CYCLES,
	parameter int TB_LONG_CYCLES  = alarm_period_pkg::TB_LONG_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        cs_n_pin,
	input  wire logic        sclk_pin,
	input  wire logic        mosi_pin,
	output logic             miso,
	output logic             miso_oe,
	input  wire logic [13:0] supply_raw,
	input  wire logic [13:0] xaccel_raw,
	input  wire logic [13:0] yaccel_raw,
	input  wire logic [13:0] aux_raw,
	input  wire logic [13:0] temp_raw,
	input  wire logic [13:0] xincl_raw,
	input  wire logic [13:0] yincl_raw,
	output logic [13:0]      supply_out,
	output logic [13:0]      xaccel_out,
	output logic [13:0]      yaccel_out,
	output logic [13:0]      aux_out,
	output logic [13:0]      temp_out,
	output logic [13:0]      xincl_out,
	output logic [13:0]      yincl_out,
	output logic             update_pulse,
	input  wire logic [15:0] first_alarm_limit,
	input  wire logic [7:0]  first_alarm_rate_samples,
	output logic             first_alarm_active,
	output logic             second_alarm_active,
	input  wire logic [1:0]  misc_line_claim,
	input  wire logic [1:0]  misc_line_value,
	input  wire logic [1:0]  gpio_line_oe,
	input  wire logic [1:0]  gpio_line_value,
	output logic [1:0]       digital_line_out,
	output logic [1:0]       digital_line_oe
);
	localparam int SW = alarm_period_pkg::SAMPLE_W;

	// Nonvolatile settings: power-up value only, untouched by reset
	logic [15:0] second_alarm_limit_reg        = alarm_period_pkg::LIMIT_RESET;
	logic [15:0] second_alarm_rate_samples_reg = alarm_period_pkg::RATE_RESET;
	logic [15:0] update_period_setting_reg     = alarm_period_pkg::PERIOD_RESET;
	logic [15:0] alarm_control_word_reg;
	logic [15:0] read_word_reg;
	logic [15:0] rx_word;
	logic        rx_valid;
	logic        wr_en;
	logic        wr_hi;
	logic [6:0]  wr_base;
	logic [7:0]  wr_data;
	logic [15:0] read_next;

	logic [17:0] base_cnt_reg;
	logic [6:0]  period_cnt_reg;
	logic [6:0]  active_count_reg;
	logic        active_long_reg;
	logic        base_tick;
	logic        update_tick;
	logic [SW-1:0] raw   [8];
	logic [SW-1:0] out_reg [alarm_period_pkg::OUTPUT_NUM];
	logic [1:0]  alarm_act;
	logic        alarm_any;
	logic        alarm_level;
	logic [1:0]  alarm_claim;
	logic [15:0] lim_sel  [2];
	logic [7:0]  rate_sel [2];
	logic [2:0]  src_sel  [2];
	logic [1:0]  rate_en;

	serial_port u_port (
		.clk      (clk),
		.reset_n  (reset_n),
		.cs_n_pin (cs_n_pin),
		.sclk_pin (sclk_pin),
		.mosi_pin (mosi_pin),
		.tx_word  (read_word_reg),
		.miso     (miso),
		.miso_oe  (miso_oe),
		.rx_word  (rx_word),
		.rx_valid (rx_valid)
	);

	// Frame: write flag, 7-bit byte address, data byte
	assign wr_en   = rx_valid && rx_word[alarm_period_pkg::WRITE_BIT];
	assign wr_hi   = rx_word[8];
	assign wr_base = {rx_word[14:9], 1'b0};
	assign wr_data = rx_word[7:0];

	always_ff @(posedge clk) begin
		if (wr_en && wr_base == alarm_period_pkg::ADDR_SECOND_ALARM_LIMIT) begin
			if (wr_hi)
				second_alarm_limit_reg[15:8] <= wr_data
					& alarm_period_pkg::LIMIT_MASK[15:8];
			else
				second_alarm_limit_reg[7:0] <= wr_data
					& alarm_period_pkg::LIMIT_MASK[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (wr_en && wr_base == alarm_period_pkg::ADDR_SECOND_ALARM_RATE) begin
			if (wr_hi)
				second_alarm_rate_samples_reg[15:8] <= wr_data
					& alarm_period_pkg::RATE_MASK[15:8];
			else
				second_alarm_rate_samples_reg[7:0] <= wr_data
					& alarm_period_pkg::RATE_MASK[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (wr_en && wr_base == alarm_period_pkg::ADDR_UPDATE_PERIOD) begin
			if (wr_hi)
				update_period_setting_reg[15:8] <= wr_data
					& alarm_period_pkg::PERIOD_MASK[15:8];
			else
				update_period_setting_reg[7:0] <= wr_data
					& alarm_period_pkg::PERIOD_MASK[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			alarm_control_word_reg <= alarm_period_pkg::CONTROL_RESET;
		else if (wr_en && wr_base == alarm_period_pkg::ADDR_ALARM_CONTROL) begin
			if (wr_hi)
				alarm_control_word_reg[15:8] <= wr_data
					& alarm_period_pkg::CONTROL_MASK[15:8];
			else
				alarm_control_word_reg[7:0] <= wr_data
					& alarm_period_pkg::CONTROL_MASK[7:0];
		end
	end

	always_comb begin
		case ({rx_word[14:9], 1'b0})
			alarm_period_pkg::ADDR_SECOND_ALARM_LIMIT:
				read_next = second_alarm_limit_reg;
			alarm_period_pkg::ADDR_SECOND_ALARM_RATE:
				read_next = second_alarm_rate_samples_reg;
			alarm_period_pkg::ADDR_ALARM_CONTROL:
				read_next = alarm_control_word_reg;
			alarm_period_pkg::ADDR_UPDATE_PERIOD:
				read_next = update_period_setting_reg;
			default:
				read_next = 16'h0000;
		endcase
	end

	// Read answer goes out during the following frame
	always_ff @(posedge clk) begin
		if (!reset_n)
			read_word_reg <= 16'h0000;
		else if (rx_valid)
			read_word_reg <= wr_en ? 16'h0000 : read_next;
	end

	// Time base; new setting takes effect at the next update boundary
	assign base_tick = base_cnt_reg == (active_long_reg
		? 18'(TB_LONG_CYCLES - 1) : 18'(TB_SHORT_CYCLES - 1));
	assign update_tick = base_tick
		&& period_cnt_reg == active_count_reg;

	always_ff @(posedge clk) begin
		if (!reset_n)
			base_cnt_reg <= 18'h00000;
		else if (base_tick)
			base_cnt_reg <= 18'h00000;
		else
			base_cnt_reg <= base_cnt_reg + 18'h00001;
	end

	// A zero count is outside the host's contract; it yields one base
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			period_cnt_reg   <= 7'h00;
			active_count_reg <= update_period_setting_reg[6:0];
			active_long_reg  <= update_period_setting_reg[7];
		end else if (update_tick) begin
			period_cnt_reg   <= 7'h00;
			active_count_reg <= update_period_setting_reg[
				alarm_period_pkg::PERIOD_COUNT_MSB:0];
			active_long_reg  <= update_period_setting_reg[
				alarm_period_pkg::PERIOD_TB_BIT];
		end else if (base_tick) begin
			period_cnt_reg <= period_cnt_reg + 7'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			update_pulse <= 1'b0;
		else
			update_pulse <= update_tick;
	end

	assign raw[0] = '0;
	assign raw[1] = supply_raw;
	assign raw[2] = xaccel_raw;
	assign raw[3] = yaccel_raw;
	assign raw[4] = aux_raw;
	assign raw[5] = temp_raw;
	assign raw[6] = xincl_raw;
	assign raw[7] = yincl_raw;

	// All seven outputs load on the same edge
	genvar gi;
	generate
		for (gi = 0; gi < alarm_period_pkg::OUTPUT_NUM; gi++) begin : g_out
			always_ff @(posedge clk) begin
				if (!reset_n)
					out_reg[gi] <= '0;
				else if (update_tick)
					out_reg[gi] <= raw[gi + 1];
			end
		end
	endgenerate

	assign supply_out = out_reg[0];
	assign xaccel_out = out_reg[1];
	assign yaccel_out = out_reg[2];
	assign aux_out    = out_reg[3];
	assign temp_out   = out_reg[4];
	assign xincl_out  = out_reg[5];
	assign yincl_out  = out_reg[6];

	assign lim_sel[0]  = first_alarm_limit;
	assign lim_sel[1]  = second_alarm_limit_reg;
	assign rate_sel[0] = first_alarm_rate_samples;
	assign rate_sel[1] = second_alarm_rate_samples_reg[
		alarm_period_pkg::RATE_COUNT_MSB:0];
	assign src_sel[0]  = alarm_control_word_reg[
		alarm_period_pkg::CTRL_SRC1_LSB +: 3];
	assign src_sel[1]  = alarm_control_word_reg[
		alarm_period_pkg::CTRL_SRC2_LSB +: 3];
	assign rate_en[0]  = alarm_control_word_reg[
		alarm_period_pkg::CTRL_RATE1_BIT];
	assign rate_en[1]  = alarm_control_word_reg[
		alarm_period_pkg::CTRL_RATE2_BIT];

	generate
		for (gi = 0; gi < 2; gi++) begin : g_alarm
			alarm_evaluator #(
				.SAMPLE_W (SW),
				.DEPTH    (alarm_period_pkg::RATE_DEPTH)
			) u_eval (
				.clk        (clk),
				.reset_n    (reset_n),
				.update     (update_tick),
				.value      (raw[src_sel[gi]]),
				.is_signed  (alarm_period_pkg::SIGNED_SOURCES[src_sel[gi]]),
				.enable     (src_sel[gi] != alarm_period_pkg::SRC_OFF),
				.rate_mode  (rate_en[gi]),
				.greater    (lim_sel[gi][alarm_period_pkg::LIMIT_GREATER_BIT]),
				.limit      (lim_sel[gi][alarm_period_pkg::LIMIT_MSB:0]),
				.rate_count (rate_sel[gi]),
				.active     (alarm_act[gi])
			);
		end
	endgenerate

	assign first_alarm_active  = alarm_act[0];
	assign second_alarm_active = alarm_act[1];

	// Pin cannot tell the alarms apart; status must be polled
	assign alarm_any   = |alarm_act;
	assign alarm_level = alarm_control_word_reg[
		alarm_period_pkg::CTRL_POLARITY_BIT] ? alarm_any : !alarm_any;
	assign alarm_claim[1] = alarm_control_word_reg[
		alarm_period_pkg::CTRL_PIN_EN_BIT] && alarm_control_word_reg[
		alarm_period_pkg::CTRL_LINE_BIT];
	assign alarm_claim[0] = alarm_control_word_reg[
		alarm_period_pkg::CTRL_PIN_EN_BIT] && !alarm_control_word_reg[
		alarm_period_pkg::CTRL_LINE_BIT];

	generate
		for (gi = 0; gi < 2; gi++) begin : g_line
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					digital_line_out[gi] <= 1'b0;
					digital_line_oe[gi]  <= 1'b0;
				end else if (misc_line_claim[gi]) begin
					digital_line_out[gi] <= misc_line_value[gi];
					digital_line_oe[gi]  <= 1'b1;
				end else if (alarm_claim[gi]) begin
					digital_line_out[gi] <= alarm_level;
					digital_line_oe[gi]  <= 1'b1;
				end else begin
					digital_line_out[gi] <= gpio_line_value[gi];
					digital_line_oe[gi]  <= gpio_line_oe[gi];
				end
			end
		end
	endgenerate
endmodule

// ### common/alarm_period_pkg.sv
// Shared constants for the alarm and update-period block.
package alarm_period_pkg;

	// Register byte addresses (low byte of each 16-bit pair)
	localparam logic [6:0] ADDR_SECOND_ALARM_LIMIT = 7'h22;
	localparam logic [6:0] ADDR_SECOND_ALARM_RATE  = 7'h26;
	localparam logic [6:0] ADDR_ALARM_CONTROL      = 7'h28;
	localparam logic [6:0] ADDR_UPDATE_PERIOD      = 7'h36;

	// Values at first power-up
	localparam logic [15:0] LIMIT_RESET   = 16'h0000;
	localparam logic [15:0] RATE_RESET    = 16'h0000;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET  = 16'h0004;

	// Writable bits; the rest read as zero
	localparam logic [15:0] LIMIT_MASK   = 16'hbfff;
	localparam logic [15:0] RATE_MASK    = 16'h00ff;
	localparam logic [15:0] CONTROL_MASK = 16'hff07;
	localparam logic [15:0] PERIOD_MASK  = 16'h00ff;

	// Field positions
	localparam int LIMIT_GREATER_BIT = 15;
	localparam int LIMIT_MSB         = 13;
	localparam int RATE_COUNT_MSB    = 7;
	localparam int CTRL_RATE2_BIT    = 15;
	localparam int CTRL_SRC2_LSB     = 12;
	localparam int CTRL_RATE1_BIT    = 11;
	localparam int CTRL_SRC1_LSB     = 8;
	localparam int CTRL_PIN_EN_BIT   = 2;
	localparam int CTRL_POLARITY_BIT = 1;
	localparam int CTRL_LINE_BIT     = 0;
	localparam int PERIOD_TB_BIT     = 7;
	localparam int PERIOD_COUNT_MSB  = 6;

	// Source codes of the control word
	localparam logic [2:0] SRC_OFF    = 3'h0;
	localparam logic [2:0] SRC_SUPPLY = 3'h1;
	localparam logic [2:0] SRC_XACCEL = 3'h2;
	localparam logic [2:0] SRC_YACCEL = 3'h3;
	localparam logic [2:0] SRC_AUX    = 3'h4;
	localparam logic [2:0] SRC_TEMP   = 3'h5;
	localparam logic [2:0] SRC_XINCL  = 3'h6;
	localparam logic [2:0] SRC_YINCL  = 3'h7;
	// Sources in two's complement, one bit per source code
	localparam logic [7:0] SIGNED_SOURCES = 8'hcc;

	localparam int SAMPLE_W    = 14;
	localparam int OUTPUT_NUM  = 7;
	localparam int RATE_DEPTH  = 256;
	localparam int FRAME_BITS  = 16;
	localparam int WRITE_BIT   = 15;

	// Time bases
	localparam int CLK_MHZ         = 40;
	localparam int TB_SHORT_NS     = 122100;
	localparam int TB_LONG_NS      = 3784000;
	localparam int TB_SHORT_CYCLES = TB_SHORT_NS * CLK_MHZ / 1000;
	localparam int TB_LONG_CYCLES  = TB_LONG_NS * CLK_MHZ / 1000;

endpackage

// ### hw/serial_port.sv
// Serial register port slave: 16-bit frames, mode 3, pins oversampled.
`timescale 1ns/1ps
module serial_port (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        cs_n_pin,
	input  wire logic        sclk_pin,
	input  wire logic        mosi_pin,
	input  wire logic [15:0] tx_word,
	output logic             miso,
	output logic             miso_oe,
	output logic [15:0]      rx_word,
	output logic             rx_valid
);
	logic [2:0]  cs_sync_reg;
	logic [2:0]  sclk_sync_reg;
	logic [2:0]  mosi_sync_reg;
	logic        cs_n_reg;
	logic        sclk_reg;
	logic        mosi_reg;
	logic [15:0] rx_shift_reg;
	logic [15:0] tx_shift_reg;
	logic [4:0]  bit_cnt_reg;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        frame_start;

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cs_sync_reg   <= 3'h7;
			sclk_sync_reg <= 3'h7;
			mosi_sync_reg <= 3'h0;
		end else begin
			cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_pin};
			sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
			mosi_sync_reg <= {mosi_sync_reg[1:0], mosi_pin};
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cs_n_reg <= 1'b1;
			sclk_reg <= 1'b1;
			mosi_reg <= 1'b0;
		end else begin
			if (cs_sync_reg[1] == cs_sync_reg[2])
				cs_n_reg <= cs_sync_reg[2];
			if (sclk_sync_reg[1] == sclk_sync_reg[2])
				sclk_reg <= sclk_sync_reg[2];
			if (mosi_sync_reg[1] == mosi_sync_reg[2])
				mosi_reg <= mosi_sync_reg[2];
		end
	end

	// Edges are decoded from the sync stages, one clock ahead of mosi_reg, so data must settle before the edge
	assign frame_start = cs_n_reg && (cs_sync_reg[1] == cs_sync_reg[2])
		&& !cs_sync_reg[2];
	assign sclk_rise = !cs_n_reg && !sclk_reg
		&& (sclk_sync_reg[1] == sclk_sync_reg[2]) && sclk_sync_reg[2];
	assign sclk_fall = !cs_n_reg && sclk_reg
		&& (sclk_sync_reg[1] == sclk_sync_reg[2]) && !sclk_sync_reg[2];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rx_shift_reg <= 16'h0000;
			tx_shift_reg <= 16'h0000;
			bit_cnt_reg  <= 5'h00;
			rx_valid     <= 1'b0;
			rx_word      <= 16'h0000;
		end else begin
			rx_valid <= 1'b0;
			if (frame_start) begin
				tx_shift_reg <= tx_word;
				bit_cnt_reg  <= 5'h00;
			end else if (sclk_rise) begin
				rx_shift_reg <= {rx_shift_reg[14:0], mosi_reg};
				bit_cnt_reg  <= bit_cnt_reg + 5'h01;
				if (bit_cnt_reg == 5'(alarm_period_pkg::FRAME_BITS - 1)) begin
					rx_word  <= {rx_shift_reg[14:0], mosi_reg};
					rx_valid <= 1'b1;
				end
			end else if (sclk_fall && bit_cnt_reg != 5'h00) begin
				tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
			end
		end
	end

	assign miso    = tx_shift_reg[15];
	assign miso_oe = !cs_n_reg;
endmodule

// ### hw/alarm_evaluator.sv
// One alarm: fixed-level or rate-of-change comparison per update.
`timescale 1ns/1ps
module alarm_evaluator #(
	parameter int SAMPLE_W = 14,
	parameter int DEPTH    = 256
) (
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                update,
	input  wire logic [SAMPLE_W-1:0] value,
	input  wire logic                is_signed,
	input  wire logic                enable,
	input  wire logic                rate_mode,
	input  wire logic                greater,
	input  wire logic [SAMPLE_W-1:0] limit,
	input  wire logic [7:0]          rate_count,
	output logic                     active
);
	logic [SAMPLE_W-1:0] history [DEPTH];
	logic [7:0]          wr_ptr_reg;
	logic [8:0]          fill_reg;
	logic [7:0]          n_eff;
	logic [SAMPLE_W-1:0] old_value;
	logic signed [23:0]  val_x;
	logic signed [23:0]  old_x;
	logic signed [23:0]  lim_x;
	logic signed [23:0]  n_x;
	logic signed [23:0]  delta;
	logic signed [23:0]  bound;
	logic signed [23:0]  lhs;
	logic                ready;
	logic                hit;

	// A zero count behaves as one sample
	assign n_eff     = (rate_count == 8'h00) ? 8'h01 : rate_count;
	assign old_value = history[wr_ptr_reg - n_eff];
	assign ready     = fill_reg >= {1'b0, n_eff};
	assign val_x = is_signed ? 24'($signed(value)) : 24'(value);
	assign old_x = is_signed ? 24'($signed(old_value)) : 24'(old_value);
	assign lim_x = is_signed ? 24'($signed(limit)) : 24'(limit);
	assign n_x   = {16'h0000, n_eff};
	// Average change over n samples, compared as delta against limit * n
	assign delta = val_x - old_x;
	assign bound = rate_mode ? lim_x * n_x : lim_x;
	assign lhs   = rate_mode ? delta : val_x;
	assign hit   = greater ? (lhs > bound) : (lhs < bound);

	always_ff @(posedge clk) begin
		if (update)
			history[wr_ptr_reg] <= value;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr_reg <= 8'h00;
			fill_reg   <= 9'h000;
		end else if (update) begin
			wr_ptr_reg <= wr_ptr_reg + 8'h01;
			if (fill_reg != 9'(DEPTH))
				fill_reg <= fill_reg + 9'h001;
		end
	end

	// Not latched: recomputed from each new sample
	always_ff @(posedge clk) begin
		if (!reset_n)
			active <= 1'b0;
		else if (update)
			active <= enable && hit && (!rate_mode || ready);
	end
endmodule

// ### verif/apc_checker.sv
// Port-level assertions for the alarm and update-period block.
`timescale 1ns/1ps
module apc_checker (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [13:0] xaccel_raw,
	input wire logic [13:0] yincl_raw,
	input wire logic [13:0] xaccel_out,
	input wire logic [13:0] yincl_out,
	input wire logic [13:0] temp_out,
	input wire logic        update_pulse,
	input wire logic        first_alarm_active,
	input wire logic        second_alarm_active,
	input wire logic [1:0]  misc_line_claim,
	input wire logic [1:0]  misc_line_value,
	input wire logic [1:0]  digital_line_out,
	input wire logic [1:0]  digital_line_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_load;
		update_pulse |-> xaccel_out == $past(xaccel_raw)
			&& yincl_out == $past(yincl_raw);
	endproperty
	a_load: assert property (p_load) else $error("group load");
	property p_out_at_upd;
		$changed(xaccel_out) |-> update_pulse;
	endproperty
	a_out_at_upd: assert property (p_out_at_upd) else $error("stray load");
	property p_hold;
		update_pulse |=> $stable(temp_out) [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("output moved");
	// Shortest legal period is two bases of 8 clocks here
	property p_gap;
		update_pulse |=> !update_pulse [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("updates too close");
	property p_alarm1_upd;
		$changed(first_alarm_active) |-> update_pulse;
	endproperty
	a_alarm1_upd: assert property (p_alarm1_upd) else $error("alarm1");
	property p_alarm2_upd;
		$changed(second_alarm_active) |-> update_pulse;
	endproperty
	a_alarm2_upd: assert property (p_alarm2_upd) else $error("alarm2");
	property p_misc0;
		misc_line_claim[0] |=> digital_line_oe[0]
			&& digital_line_out[0] == $past(misc_line_value[0]);
	endproperty
	a_misc0: assert property (p_misc0) else $error("line zero claim");
	property p_misc1;
		misc_line_claim[1] |=> digital_line_oe[1]
			&& digital_line_out[1] == $past(misc_line_value[1]);
	endproperty
	a_misc1: assert property (p_misc1) else $error("line one claim");
	c_upd: cover property (update_pulse);
	c_both: cover property (first_alarm_active && second_alarm_active);
	c_pin: cover property (digital_line_oe[0] && !misc_line_claim[0]);
endmodule

// ### verif/host_model.sv
// Host serial master model for the register port.
`timescale 1ns/1ps
module host_model (
	input  wire logic clk,
	output logic      cs_n_pin,
	output logic      sclk_pin,
	output logic      mosi_pin,
	input  wire logic miso,
	input  wire logic miso_oe
);
	initial begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b1;
		mosi_pin = 1'b0;
	end
	// Phases of 8 clocks clear the device pin filter with margin
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		@(negedge clk);
		cs_n_pin = 1'b0;
		repeat (8) @(negedge clk);
		for (int i = 15; i >= 0; i--) begin
			sclk_pin = 1'b0;
			mosi_pin = w[i];
			repeat (8) @(negedge clk);
			// Taken at the rise; from the second bit on, the device shifts on the fall before it
			r[i] = miso_oe ? miso : 1'bx;
			sclk_pin = 1'b1;
			repeat (8) @(negedge clk);
		end
		cs_n_pin = 1'b1;
		// Released data line must not keep the last bit
		mosi_pin = ~mosi_pin;
		repeat (8) @(negedge clk);
	endtask
endmodule

// ### verif/tb_top.sv
// Bench for the alarm and update-period block with a serial host.
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cs_n_pin, sclk_pin, mosi_pin, miso, miso_oe;
	logic [13:0] raw [7];
	logic [13:0] out [7];
	logic [15:0] lim1 = 16'h0000;
	logic [7:0]  smp1 = 8'h00;
	logic [1:0]  mclaim = 2'h0, mval = 2'h0, goe = 2'h0, gval = 2'h0;
	logic [1:0]  lout, loe;
	logic        act1, act2, upd;
	int          n_mismatch = 0, samples_checked = 0, cycles = 0;
	always #12.5 clk = ~clk;
	initial foreach (raw[i]) raw[i] = 14'h0000;
	host_model host_u (.clk(clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
		.mosi_pin(mosi_pin), .miso(miso), .miso_oe(miso_oe));
	alarm_period_control #(.TB_SHORT_CYCLES(8), .TB_LONG_CYCLES(20)) dut_u (
		.clk(clk), .reset_n(reset_n), .cs_n_pin(cs_n_pin),
		.sclk_pin(sclk_pin), .mosi_pin(mosi_pin), .miso(miso),
		.miso_oe(miso_oe), .supply_raw(raw[0]), .xaccel_raw(raw[1]),
		.yaccel_raw(raw[2]), .aux_raw(raw[3]), .temp_raw(raw[4]),
		.xincl_raw(raw[5]), .yincl_raw(raw[6]), .supply_out(out[0]),
		.xaccel_out(out[1]), .yaccel_out(out[2]), .aux_out(out[3]),
		.temp_out(out[4]), .xincl_out(out[5]), .yincl_out(out[6]),
		.update_pulse(upd), .first_alarm_limit(lim1),
		.first_alarm_rate_samples(smp1), .first_alarm_active(act1),
		.second_alarm_active(act2), .misc_line_claim(mclaim),
		.misc_line_value(mval), .gpio_line_oe(goe), .gpio_line_value(gval),
		.digital_line_out(lout), .digital_line_oe(loe));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		logic [15:0] r;
		host_u.xfer({1'b1, a, v[7:0]}, r);
		host_u.xfer({1'b1, a + 7'h01, v[15:8]}, r);
	endtask
	// Read answer arrives in the frame after the request
	task automatic rdc(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] r;
		host_u.xfer({1'b0, a, 8'h00}, r);
		host_u.xfer(16'h0000, r);
		chk("register", e, r);
	endtask
	task automatic wait_upd(input int n);
		int k;
		repeat (n) begin
			k = 0;
			@(negedge clk);
			while (upd !== 1'b1 && k < 6000) begin
				@(negedge clk);
				k++;
			end
			if (k >= 6000) chk("update", 16'h0001, 16'h0000);
		end
		@(negedge clk);
	endtask
	task automatic set_all(input logic [13:0] v);
		foreach (raw[i]) raw[i] = v;
	endtask
	task automatic s_regs;
		rdc(7'h22, 16'h0000);
		rdc(7'h26, 16'h0000);
		rdc(7'h28, 16'h0000);
		rdc(7'h36, 16'h0004);
		wr(7'h30, 16'hffff);
		rdc(7'h30, 16'h0000);
		wr(7'h22, 16'hffff);
		rdc(7'h22, 16'hbfff);
		wr(7'h26, 16'hffff);
		rdc(7'h26, 16'h00ff);
		wr(7'h28, 16'hffff);
		rdc(7'h28, 16'hff07);
		wr(7'h36, 16'hff81);
		rdc(7'h36, 16'h0081);
		@(negedge clk);
		reset_n = 1'b0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		rdc(7'h22, 16'hbfff);
		rdc(7'h26, 16'h00ff);
		rdc(7'h28, 16'h0000);
		rdc(7'h36, 16'h0081);
	endtask
	task automatic period_case(input logic [15:0] set, input int e);
		int t;
		t = 1;
		wr(7'h36, set);
		wait_upd(2);
		while (upd !== 1'b1 && t < 6000) begin
			@(negedge clk);
			t++;
		end
		chk("period", e[15:0], t[15:0]);
	endtask
	task automatic s_fixed;
		logic sgn;
		wr(7'h22, 16'h8064);
		for (int s = 1; s < 8; s++) begin
			sgn = (s == 2 || s == 3 || s >= 6);
			wr(7'h28, 16'(s) << 12);
			set_all(14'h0032);
			wait_upd(2);
			chk("alarm2", 16'h0000, {15'h0, act2});
			set_all(14'h00c8);
			wait_upd(2);
			chk("alarm2", 16'h0001, {15'h0, act2});
			set_all(14'h3fff);
			wait_upd(2);
			chk("alarm2", {15'h0, !sgn}, {15'h0, act2});
		end
		wr(7'h28, 16'h0000);
		wait_upd(2);
		chk("alarm2", 16'h0000, {15'h0, act2});
		wr(7'h22, 16'h0064);
		wr(7'h28, 16'h1000);
		set_all(14'h0032);
		wait_upd(2);
		chk("alarm2", 16'h0001, {15'h0, act2});
		set_all(14'h00c8);
		wait_upd(2);
		chk("alarm2", 16'h0000, {15'h0, act2});
	endtask
	task automatic s_pin;
		logic [2:0] p;
		logic [1:0] e;
		wr(7'h22, 16'h8064);
		for (int k = 0; k < 8; k++) begin
			p = 3'(k);
			e = p[2] ? (p[0] ? 2'b10 : 2'b01) : 2'b00;
			wr(7'h28, 16'h1000 | 16'(p));
			wait_upd(2);
			chk("line_oe", {14'h0, e}, {14'h0, loe});
			if (p[2]) chk("line_out", {15'h0, p[1]}, {15'h0, lout[p[0]]});
		end
		lim1 = 16'h8064;
		wr(7'h28, 16'h0106);
		wait_upd(2);
		chk("line_out", 16'h0001, {15'h0, lout[0]});
		set_all(14'h0032);
		wr(7'h28, 16'h0104);
		wait_upd(2);
		chk("line_out", 16'h0001, {15'h0, lout[0]});
		set_all(14'h00c8);
		wr(7'h28, 16'h0106);
		goe = 2'b11;
		gval = 2'b10;
		wait_upd(2);
		chk("lines", 16'h0003, {14'h0, lout});
		mclaim = 2'b01;
		repeat (2) @(negedge clk);
		chk("lines", 16'h0002, {14'h0, lout});
		mclaim = 2'b10;
		mval = 2'b00;
		repeat (2) @(negedge clk);
		chk("lines", 16'h0001, {14'h0, lout});
		chk("line_oe", 16'h0003, {14'h0, loe});
		mclaim = 2'b00;
		goe = 2'b00;
	endtask
	task automatic s_rate;
		wr(7'h22, 16'h800a);
		wr(7'h26, 16'h0002);
		lim1 = 16'h800a;
		smp1 = 8'h02;
		wr(7'h28, 16'h9900);
		repeat (5) begin
			raw[0] = raw[0] + 14'h001e;
			wait_upd(1);
		end
		chk("alarms", 16'h0003, {14'h0, act1, act2});
		wait_upd(4);
		chk("alarms", 16'h0000, {14'h0, act1, act2});
		wr(7'h28, 16'h1100);
		wait_upd(2);
		chk("alarms", 16'h0003, {14'h0, act1, act2});
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 90000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		s_regs();
		period_case(16'h0081, 40);
		period_case(16'h0003, 32);
		period_case(16'h0001, 16);
		foreach (raw[i]) raw[i] = 14'h0100 + 14'(i);
		wait_upd(1);
		foreach (out[i]) chk("output", {2'b00, raw[i]}, {2'b00, out[i]});
		s_fixed();
		s_pin();
		s_rate();
		end_sim();
	end
endmodule
bind alarm_period_control apc_checker chk_u (.*);
